// file: core/rsc_axil_slave.sv
// AXI4-Lite slave front end for the reference select registers
`timescale 1ns/100ps
module rsc_axil_slave
  import rsc_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // Write channels
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // Read channels
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // Register side
  output logic                   wr_fire,
  output rsc_wr_s                wr_req,
  output logic                   rd_fire,
  output rsc_rsel_e              rd_sel,
  input  wire logic [31:0]       rd_data
);

  logic              aw_full_reg, aw_full_next, w_full_reg, w_full_next;
  logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
  logic [7:0]        w_data_reg, w_data_next;
  logic              w_lane_reg, w_lane_next;
  logic              awready_reg, awready_next, wready_reg, wready_next;
  logic              bvalid_reg, bvalid_next, arready_reg, arready_next;
  logic              rvalid_reg, rvalid_next;
  logic [1:0]        bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0]       rdata_reg, rdata_next;
  logic              hit_ctrl, hit_aux, hit_stat, rd_ok;

  // Address decode of the held write and the offered read
  always_comb begin
    hit_ctrl = aw_addr_reg == ADDR_W'(RSC_OFF_CTRL);
    hit_aux  = aw_addr_reg == ADDR_W'(RSC_OFF_AUX);
    hit_stat = aw_addr_reg == ADDR_W'(RSC_OFF_STAT);
    rd_ok    = 1'b1;
    rd_sel   = RSC_RD_STAT;
    if (araddr == ADDR_W'(RSC_OFF_CTRL)) begin
      rd_sel = RSC_RD_CTRL;
    end else if (araddr == ADDR_W'(RSC_OFF_AUX)) begin
      rd_sel = RSC_RD_AUX;
    end else if (araddr != ADDR_W'(RSC_OFF_STAT)) begin
      rd_ok = 1'b0;
    end
  end

  // Write on the edge after address and data are both held
  assign wr_fire     = aw_full_reg & w_full_reg;
  assign wr_req.ctrl = hit_ctrl & w_lane_reg;
  assign wr_req.aux  = hit_aux & w_lane_reg;
  assign wr_req.data = w_data_reg;
  assign rd_fire     = arvalid & arready_reg;

  // Channel state next values
  always_comb begin
    aw_full_next = aw_full_reg;
    aw_addr_next = aw_addr_reg;
    w_full_next  = w_full_reg;
    w_data_next  = w_data_reg;
    w_lane_next  = w_lane_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    rvalid_next  = rvalid_reg;
    rresp_next   = rresp_reg;
    rdata_next   = rdata_reg;
    if (awvalid && awready_reg) begin
      aw_full_next = 1'b1;
      aw_addr_next = awaddr;
    end
    if (wvalid && wready_reg) begin
      w_full_next = 1'b1;
      w_data_next = wdata[7:0];
      w_lane_next = wstrb[0];
    end
    if (bvalid_reg && bready) begin
      bvalid_next = 1'b0;
    end
    if (wr_fire) begin
      aw_full_next = 1'b0;
      w_full_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = (hit_ctrl || hit_aux) ? RSC_RESP_OKAY :
                     hit_stat ? RSC_RESP_SLVERR : RSC_RESP_DECERR;
    end
    if (rvalid_reg && rready) begin
      rvalid_next = 1'b0;
    end
    if (rd_fire) begin
      rvalid_next = 1'b1;
      rdata_next  = rd_ok ? rd_data : 32'h0;
      rresp_next  = rd_ok ? RSC_RESP_OKAY : RSC_RESP_DECERR;
    end
    awready_next = !aw_full_next && !bvalid_next;
    wready_next  = !w_full_next && !bvalid_next;
    arready_next = !rvalid_next;
  end

  // Channel state registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_full_reg  <= 1'b0;
      w_data_reg  <= 8'h00;
      w_lane_reg  <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RSC_RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= RSC_RESP_OKAY;
      rdata_reg   <= 32'h0;
    end else begin
      aw_full_reg <= aw_full_next;
      aw_addr_reg <= aw_addr_next;
      w_full_reg  <= w_full_next;
      w_data_reg  <= w_data_next;
      w_lane_reg  <= w_lane_next;
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg  <= rvalid_next;
      rresp_reg   <= rresp_next;
      rdata_reg   <= rdata_next;
    end
  end

  // Bus outputs straight from flops
  assign awready = awready_reg;
  assign wready  = wready_reg;
  assign bvalid  = bvalid_reg;
  assign bresp   = bresp_reg;
  assign arready = arready_reg;
  assign rvalid  = rvalid_reg;
  assign rresp   = rresp_reg;
  assign rdata   = rdata_reg;

endmodule

// file: core/rsc_ref_select.sv
// Reference select control: registers and analog switch decode
//
// Register access over AXI4-Lite and the address map are this design's own decisions.
`timescale 1ns/100ps
module rsc_ref_select
  import rsc_pkg::*;
#(
  parameter int AXI_ADDR_W = 12
) (
  // Clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // Write address channel
  input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]            s_axi_awprot,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  // Write data channel
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  // Write response channel
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // Read address channel
  input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]            s_axi_arprot,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  // Read data channel
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Oscillator status
  input  wire logic                  fast_internal_oscillator,
  // Analog switch controls
  output rsc_ref_s                   ref_ctrl
);

  logic [7:0]  ctrl_reg, ctrl_next;
  logic [4:0]  aux_reg, aux_next;
  rsc_ref_s    ref_reg, ref_next;
  logic        wr_fire, rd_fire;
  rsc_wr_s     wr_req;
  rsc_rsel_e   rd_sel;
  logic [31:0] rd_data;
  logic        src, pin_oe, adcp, adcn, c1, c2;
  logic [6:0]  tap7;

  // Bus front end
  rsc_axil_slave #(
    .ADDR_W (AXI_ADDR_W)
  ) rsc_axil_slave_inst (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .bresp   (s_axi_bresp),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .araddr  (s_axi_araddr),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .wr_fire (wr_fire),
    .wr_req  (wr_req),
    .rd_fire (rd_fire),
    .rd_sel  (rd_sel),
    .rd_data (rd_data)
  );

  // Register next values; reads never change state
  always_comb begin
    ctrl_next = ctrl_reg;
    aux_next  = aux_reg;
    if (wr_fire && wr_req.ctrl) begin
      ctrl_next = wr_req.data;
    end
    if (wr_fire && wr_req.aux) begin
      aux_next = wr_req.data[RSC_AUX_W-1:0];
    end
  end

  // Read data mux
  always_comb begin
    unique case (rd_sel)
      RSC_RD_CTRL: rd_data = {24'h0, ctrl_reg};
      RSC_RD_AUX:  rd_data = {27'h0, aux_reg};
      RSC_RD_STAT: rd_data = 32'(ref_reg);
      default:     rd_data = 32'h0;
    endcase
  end

  // Field picks from the next register values
  assign src    = ctrl_next[RSC_SRC_BIT];
  assign pin_oe = ctrl_next[RSC_PIN_OE_BIT];
  assign adcp   = aux_next[RSC_ADCP_BIT];
  assign adcn   = aux_next[RSC_ADCN_BIT];
  assign c1     = aux_next[RSC_C1_BIT];
  assign c2     = aux_next[RSC_C2_BIT];
  assign tap7   = {3'h0, ctrl_next[RSC_TAP_LSB +: RSC_TAP_W]};

  // Switch decode, so outputs move on the writing edge
  always_comb begin
    ref_next = '0;
    ref_next.ladder_power_enable     = ctrl_next[RSC_PWR_BIT];
    ref_next.ladder_range_low_select = ctrl_next[RSC_RANGE_BIT];
    ref_next.ladder_source_select    = src;
    ref_next.ladder_tap_value        = ctrl_next[RSC_TAP_LSB +: RSC_TAP_W];
    ref_next.comp1_ladder_route      = c1;
    ref_next.comp2_ladder_route      = c2;
    ref_next.ladder_current_enable   = c1 | c2;
    ref_next.fixed_ref_on  = aux_next[RSC_FIX_BIT] | fast_internal_oscillator;
    ref_next.comp_pos_ext  = src;
    ref_next.comp_neg_ext  = src & (~pin_oe | adcn);
    ref_next.adc_pos_ext   = adcp;
    ref_next.adc_neg_ext   = adcn;
    ref_next.pin3_ext_high = src | adcp;
    // Ladder ratio in 96ths, range picks the formula
    if (ctrl_next[RSC_RANGE_BIT]) begin
      ref_next.ladder_ratio = tap7 * RSC_LOW_STEP;
    end else begin
      ref_next.ladder_ratio = RSC_HIGH_BASE + tap7 * RSC_HIGH_STEP;
    end
    // Pin two function
    if (pin_oe && !adcn) begin
      ref_next.pin2_func = RSC_PIN2_LADDER;
    end else if (adcn || src) begin
      ref_next.pin2_func = RSC_PIN2_EXT_LOW;
    end else begin
      ref_next.pin2_func = RSC_PIN2_IO;
    end
  end

  // State registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= RSC_CTRL_RST;
      aux_reg  <= RSC_AUX_RST;
      ref_reg  <= '{pin2_func: RSC_PIN2_IO, ladder_ratio: RSC_HIGH_BASE, default: 1'b0};
    end else begin
      ctrl_reg <= ctrl_next;
      aux_reg  <= aux_next;
      ref_reg  <= ref_next;
    end
  end

  // Analog controls straight from flops
  assign ref_ctrl = ref_reg;

  // Checks on the decode and register behaviour
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_ctrl_write;
    wr_fire && wr_req.ctrl;
  endsequence

  sequence s_quiet_read;
    rd_fire && !wr_fire;
  endsequence

  sequence s_aux_write;
    wr_fire && wr_req.aux;
  endsequence

  sequence s_ctrl_read;
    rd_fire && rd_sel == RSC_RD_CTRL;
  endsequence

  sequence s_aux_read;
    rd_fire && rd_sel == RSC_RD_AUX;
  endsequence

  sequence s_stat_read;
    rd_fire && rd_sel == RSC_RD_STAT;
  endsequence

  property p_aux_lands;
    logic [7:0] d;
    (s_aux_write, d = wr_req.data) |=>
      aux_reg == d[RSC_AUX_W-1:0] && ref_reg.comp1_ladder_route == d[RSC_C1_BIT]
      && ref_reg.comp2_ladder_route == d[RSC_C2_BIT];
  endproperty

  property p_write_lands;
    logic [7:0] d;
    (s_ctrl_write, d = wr_req.data) |=>
      ctrl_reg == d && ref_reg.ladder_tap_value == d[3:0]
      && ref_reg.ladder_power_enable == d[7];
  endproperty

  AST_C1_ROUTE: assert property (ref_reg.comp1_ladder_route == aux_reg[RSC_C1_BIT])
    else $error("comp1 route does not follow select");

  AST_C2_ROUTE: assert property (ref_reg.comp2_ladder_route == aux_reg[RSC_C2_BIT])
    else $error("comp2 route does not follow select");

  AST_CURRENT: assert property (
    ref_reg.ladder_current_enable == (aux_reg[RSC_C1_BIT] | aux_reg[RSC_C2_BIT]))
    else $error("ladder current wrong for selects");

  AST_POWER: assert property ($changed(ctrl_reg[RSC_PWR_BIT]) |->
    $changed(ref_reg.ladder_power_enable))
    else $error("power enable did not move with bit");

  AST_PIN_OUT: assert property (
    (ctrl_reg[RSC_PIN_OE_BIT] && !aux_reg[RSC_ADCN_BIT]) == (ref_reg.pin2_func == RSC_PIN2_LADDER))
    else $error("ladder to pin two wrong");

  AST_LOW_RANGE: assert property (ctrl_reg[RSC_RANGE_BIT] |->
    ref_reg.ladder_ratio == 7'(ctrl_reg[3:0] * 4))
    else $error("low range ratio wrong");

  AST_HIGH_RANGE: assert property (!ctrl_reg[RSC_RANGE_BIT] |->
    ref_reg.ladder_ratio == 7'(24 + ctrl_reg[3:0] * 3))
    else $error("high range ratio wrong");

  AST_SOURCE: assert property (ref_reg.ladder_source_select == ctrl_reg[RSC_SRC_BIT])
    else $error("source select wrong");

  AST_RESET: assert property (disable iff (1'b0) !aresetn |=> ctrl_reg == 8'h00
    && ref_reg.pin2_func == RSC_PIN2_IO)
    else $error("control register not cleared by reset");

  AST_COMP_NEG: assert property (ref_reg.comp_neg_ext == (ctrl_reg[RSC_SRC_BIT]
    && (!ctrl_reg[RSC_PIN_OE_BIT] || aux_reg[RSC_ADCN_BIT])))
    else $error("comparator negative reference wrong");

  AST_ADC_REF: assert property ({ref_reg.adc_pos_ext, ref_reg.adc_neg_ext} ==
    {aux_reg[RSC_ADCP_BIT], aux_reg[RSC_ADCN_BIT]})
    else $error("ADC reference wrong");

  AST_PIN3: assert property (ref_reg.pin3_ext_high ==
    (ctrl_reg[RSC_SRC_BIT] || aux_reg[RSC_ADCP_BIT]))
    else $error("pin three function wrong");

  AST_PIN2_EXT: assert property ((ref_reg.pin2_func == RSC_PIN2_EXT_LOW) ==
    (aux_reg[RSC_ADCN_BIT] || (ctrl_reg[RSC_SRC_BIT] && !ctrl_reg[RSC_PIN_OE_BIT])))
    else $error("pin two external low wrong");

  AST_FIXED: assert property (##1 ref_reg.fixed_ref_on ==
    (aux_reg[RSC_FIX_BIT] || $past(fast_internal_oscillator)))
    else $error("fixed reference enable wrong");

  AST_WRITE: assert property (p_write_lands)
    else $error("write did not land on completing edge");

  AST_READ_INERT: assert property (s_quiet_read |=> $stable(ctrl_reg) && $stable(aux_reg))
    else $error("read changed register state");

  AST_AUX_WRITE: assert property (p_aux_lands)
    else $error("selection write did not land");

  // Bus answers one cycle after the write fires or the read handshake
  AST_BVALID_RISE: assert property (wr_fire |=> s_axi_bvalid)
    else $error("write response late");

  AST_RVALID_RISE: assert property (rd_fire |=> s_axi_rvalid)
    else $error("read response late");

  // Read data carry the stored value of the taking edge
  AST_RDATA_CTRL: assert property (s_ctrl_read |=>
    s_axi_rdata == {24'h0, $past(ctrl_reg)})
    else $error("control read data wrong");

  AST_RDATA_AUX: assert property (s_aux_read |=>
    s_axi_rdata == {27'h0, $past(aux_reg)})
    else $error("selection read data wrong");

  AST_RDATA_STAT: assert property (s_stat_read |=>
    s_axi_rresp != RSC_RESP_OKAY || s_axi_rdata == 32'($past(ref_reg)))
    else $error("status read data wrong");

  // Register state moves only on a landing write
  AST_HOLD: assert property (!(wr_fire && (wr_req.ctrl || wr_req.aux)) |=>
    $stable(ctrl_reg) && $stable(aux_reg))
    else $error("register changed without a write");

  // Bus ready again on the first edge after reset
  AST_READY_RESET: assert property ($rose(aresetn) |=> s_axi_awready && s_axi_wready
    && s_axi_arready && !s_axi_bvalid && !s_axi_rvalid)
    else $error("bus not ready after reset");

  // Remaining direct field copies and the pin two one-hot check
  AST_RANGE_FLAG: assert property (
    ref_reg.ladder_range_low_select == ctrl_reg[RSC_RANGE_BIT])
    else $error("range flag wrong");

  AST_TAP: assert property (
    ref_reg.ladder_tap_value == ctrl_reg[RSC_TAP_LSB +: RSC_TAP_W])
    else $error("tap value wrong");

  AST_COMP_POS: assert property (ref_reg.comp_pos_ext == ctrl_reg[RSC_SRC_BIT])
    else $error("comparator positive reference wrong");

  AST_PIN2_ONEHOT: assert property ($onehot(ref_reg.pin2_func))
    else $error("pin two function not one-hot");

endmodule

// file: shared/rsc_pkg.sv
// Constants and types for the reference select control block
package rsc_pkg;

  // Register offsets
  localparam logic [3:0] RSC_OFF_CTRL = 4'h0;
  localparam logic [3:0] RSC_OFF_AUX  = 4'h4;
  localparam logic [3:0] RSC_OFF_STAT = 4'h8;

  // Ladder control register fields
  localparam int RSC_CTRL_W     = 8;
  localparam int RSC_PWR_BIT    = 7;
  localparam int RSC_PIN_OE_BIT = 6;
  localparam int RSC_RANGE_BIT  = 5;
  localparam int RSC_SRC_BIT    = 4;
  localparam int RSC_TAP_LSB    = 0;
  localparam int RSC_TAP_W      = 4;

  // Selection register fields
  localparam int RSC_AUX_W      = 5;
  localparam int RSC_C1_BIT     = 0;
  localparam int RSC_C2_BIT     = 1;
  localparam int RSC_ADCP_BIT   = 2;
  localparam int RSC_ADCN_BIT   = 3;
  localparam int RSC_FIX_BIT    = 4;

  // Reset values
  localparam logic [7:0] RSC_CTRL_RST = 8'h00;
  localparam logic [4:0] RSC_AUX_RST  = 5'h00;

  // Tap ratio in 96ths of the ladder source
  localparam int RSC_RATIO_DEN   = 96;
  localparam int RSC_LOW_DIV     = 24;
  localparam int RSC_HIGH_DIV    = 32;
  localparam int RSC_QUARTER_DIV = 4;
  localparam logic [6:0] RSC_LOW_STEP  = 7'(RSC_RATIO_DEN / RSC_LOW_DIV);
  localparam logic [6:0] RSC_HIGH_STEP = 7'(RSC_RATIO_DEN / RSC_HIGH_DIV);
  localparam logic [6:0] RSC_HIGH_BASE = 7'(RSC_RATIO_DEN / RSC_QUARTER_DIV);

  // Bus responses
  localparam logic [1:0] RSC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] RSC_RESP_SLVERR = 2'h2;
  localparam logic [1:0] RSC_RESP_DECERR = 2'h3;

  // Port A bit 2 pin function
  typedef enum logic [2:0] {
    RSC_PIN2_IO      = 3'h1,
    RSC_PIN2_LADDER  = 3'h2,
    RSC_PIN2_EXT_LOW = 3'h4
  } rsc_pin2_e;

  // Read selection from the bus slave
  typedef enum logic [1:0] {
    RSC_RD_CTRL = 2'h0,
    RSC_RD_AUX  = 2'h1,
    RSC_RD_STAT = 2'h2
  } rsc_rsel_e;

  // Register write request
  typedef struct packed {
    logic       ctrl;
    logic       aux;
    logic [7:0] data;
  } rsc_wr_s;

  // Analog switch controls, also the status word
  typedef struct packed {
    logic [6:0] ladder_ratio;
    rsc_pin2_e  pin2_func;
    logic       pin3_ext_high;
    logic       adc_neg_ext;
    logic       adc_pos_ext;
    logic       comp_neg_ext;
    logic       comp_pos_ext;
    logic       comp2_ladder_route;
    logic       comp1_ladder_route;
    logic       fixed_ref_on;
    logic       ladder_current_enable;
    logic       ladder_power_enable;
    logic       ladder_range_low_select;
    logic       ladder_source_select;
    logic [3:0] ladder_tap_value;
  } rsc_ref_s;

endpackage

// file: tb/reference_select_control_test.sv
// Self-checking bench for the reference select control block
`timescale 1ns/100ps
module reference_select_control_test
  import rsc_pkg::*;
;
  logic        aclk, aresetn, osc_req, osc_on, osc_m;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_v;
  logic [3:0]  wstrb;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp, rsp_v;
  logic [7:0]  ctrl_m, aux_m;
  rsc_ref_s    ref_ctrl;
  int          err_count, n_compared;

  // Clock, 4 ns period
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  rsc_osc_model rsc_osc_model_inst (.aclk(aclk), .aresetn(aresetn), .run_req(osc_req),
    .osc_running(osc_on));

  rsc_ref_select rsc_ref_select_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .fast_internal_oscillator(osc_on), .ref_ctrl(ref_ctrl));

  // Verdict and end of run
  task automatic test_done();
    if (err_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Value compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Expected switch controls from the register model
  function automatic rsc_ref_s exp_ref(input logic [7:0] c, input logic [7:0] x,
                                       input logic o);
    rsc_ref_s e;
    logic     s, oe, n;
    s = c[4];
    oe = c[6];
    n = x[3];
    e = '0;
    e.ladder_tap_value = c[3:0];
    e.ladder_source_select = s;
    e.ladder_range_low_select = c[5];
    e.ladder_power_enable = c[7];
    e.ladder_current_enable = x[0] | x[1];
    e.comp1_ladder_route = x[0];
    e.comp2_ladder_route = x[1];
    e.fixed_ref_on = x[4] | o;
    e.comp_pos_ext = s;
    e.comp_neg_ext = s & (~oe | n);
    e.adc_pos_ext = x[2];
    e.adc_neg_ext = n;
    e.pin3_ext_high = s | x[2];
    e.pin2_func = (oe & ~n) ? RSC_PIN2_LADDER :
                  (n | (s & ~oe)) ? RSC_PIN2_EXT_LOW : RSC_PIN2_IO;
    e.ladder_ratio = c[5] ? 7'(c[3:0]) * 7'h4 : 7'h18 + 7'(c[3:0]) * 7'h3;
    return e;
  endfunction

  task automatic chk_ref();
    chk({6'h0, ref_ctrl}, {6'h0, exp_ref(ctrl_m, aux_m, osc_m)});
  endtask

  // Write cycle, address and data offered together
  task automatic axi_wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
                        output logic [1:0] r);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (n == 40) begin
      chk(32'h0, 32'h1);
      test_done();
    end
    r = bresp;
    bready <= 1'b0;
  endtask

  // Read cycle
  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (n == 40) begin
      chk(32'h0, 32'h1);
      test_done();
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // Mapped write, model update and output check
  task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    axi_wr(a, d, 4'h1, rsp_v);
    if (a == 12'h0) ctrl_m = d;
    else aux_m = d & 8'h1f;
    chk({30'h0, rsp_v}, 32'h0);
    chk_ref();
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    axi_rd(a, rd_v, rsp_v);
    chk(rd_v, e);
    chk({30'h0, rsp_v}, {30'h0, er});
  endtask

  task automatic do_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    ctrl_m = 8'h00;
    aux_m = 8'h00;
  endtask

  // Reset values and status word
  task automatic sc_reset();
    rd_chk(12'h0, 32'h0, 2'h0);
    rd_chk(12'h4, 32'h0, 2'h0);
    chk_ref();
    rd_chk(12'h8, {6'h0, exp_ref(ctrl_m, aux_m, osc_m)}, 2'h0);
  endtask

  // Every control bit writable and readable; strobe-less write inert
  task automatic sc_rw();
    wr_reg(12'h0, 8'hff);
    rd_chk(12'h0, 32'hff, 2'h0);
    axi_wr(12'h0, 8'h00, 4'h0, rsp_v);
    chk({30'h0, rsp_v}, 32'h0);
    chk_ref();
    wr_reg(12'h0, 8'h00);
    rd_chk(12'h0, 32'h0, 2'h0);
  endtask

  // Every tap in both ranges
  task automatic sc_tap();
    for (int i = 0; i < 32; i++) wr_reg(12'h0, {2'b10, i[4], 1'b0, i[3:0]});
  endtask

  // Full selection table with both comparator selects
  task automatic sc_table();
    for (int i = 0; i < 64; i++) begin
      wr_reg(12'h4, {4'h0, i[3:0]});
      wr_reg(12'h0, {1'b0, i[4], 1'b0, i[5], 4'h9});
    end
  endtask

  // Fixed reference by bit and by oscillator
  task automatic sc_fixed();
    wr_reg(12'h4, 8'h10);
    rd_chk(12'h4, 32'h10, 2'h0);
    osc_req <= 1'b1;
    repeat (8) @(posedge aclk);
    osc_m = 1'b1;
    wr_reg(12'h4, 8'h00);
    osc_req <= 1'b0;
    repeat (8) @(posedge aclk);
    osc_m = 1'b0;
    chk_ref();
  endtask

  // Refused accesses leave state alone
  task automatic sc_err();
    wr_reg(12'h0, 8'h3c);
    axi_wr(12'h10, 8'hff, 4'h1, rsp_v);
    chk({30'h0, rsp_v}, 32'h3);
    axi_wr(12'h8, 8'hff, 4'h1, rsp_v);
    chk({30'h0, rsp_v}, 32'h2);
    chk_ref();
    rd_chk(12'h404, 32'h0, 2'h3);
    rd_chk(12'h0, 32'h3c, 2'h0);
  endtask

  // Main sequence
  initial begin
    aresetn = 1'b0;
    osc_req = 1'b0;
    osc_m = 1'b0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    err_count = 0;
    n_compared = 0;
    do_reset();
    sc_reset();
    sc_rw();
    sc_tap();
    sc_table();
    sc_fixed();
    sc_err();
    wr_reg(12'h4, 8'h1f);
    do_reset();
    sc_reset();
    test_done();
  end
endmodule

// file: tb/rsc_osc_model.sv
// Oscillator stand-in that drives the block's oscillator status input
`timescale 1ns/100ps
module rsc_osc_model
  import rsc_pkg::*;
#(
  parameter int START_CYC = 3
) (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Bench request
  input  wire logic run_req,
  // Oscillator status
  output logic      osc_running
);
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;

  // Start-up count; stopping is immediate
  always_comb begin
    cnt_next = run_req ? cnt_reg : 4'h0;
    if (run_req && cnt_reg != 4'(START_CYC)) cnt_next = cnt_reg + 4'h1;
  end

  // Register the count
  always_ff @(posedge aclk) begin
    if (!aresetn) cnt_reg <= 4'h0;
    else cnt_reg <= cnt_next;
  end

  assign osc_running = (cnt_reg == 4'(START_CYC));
endmodule
